// ---- inc/drc_pkg.sv ----
// constants shared by the dram host controller
`default_nettype none
package drc_pkg;
    // ------------------------------------------------------------------
    // clock and timing figures
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int PWR_PAUSE_US = 200;
    localparam int SR_LOW_TIME_US = 100;       // self_refresh_low_time
    localparam int SR_PRECHARGE_TIME_NS = 150; // self_refresh_precharge_time
    localparam int REF_INTERVAL_NS = 15600;
    // least times round up, the refresh interval (a longest time) down
    localparam int PWR_PAUSE_CYC =
        (PWR_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SR_LOW_CYC =
        (SR_LOW_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SR_PRE_CYC =
        (SR_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_INT_CYC = REF_INTERVAL_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------------
    // counts and widths
    // ------------------------------------------------------------------
    localparam int INIT_CYCLES = 8;
    localparam int ROW_COUNT = 2048;
    localparam int CNT_W = 12;
    localparam int ROWS_W = 12;
    localparam int ADDR_W = 11;
    localparam int COL_W = 10;
    localparam int DATA_W = 8;
    localparam logic [CNT_W-1:0] PWR_PAUSE_LAST = CNT_W'(PWR_PAUSE_CYC - 1);
    localparam logic [CNT_W-1:0] SR_LOW_LAST = CNT_W'(SR_LOW_CYC - 1);
    localparam logic [CNT_W-1:0] SR_PRE_LAST = CNT_W'(SR_PRE_CYC - 1);
    localparam logic [7:0] REF_INT_LAST = 8'(REF_INT_CYC - 1);
    localparam logic [3:0] INIT_LOAD = 4'(INIT_CYCLES);
    localparam logic [ROWS_W-1:0] ROWS_FULL = ROWS_W'(ROW_COUNT);
    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_PWR_WAIT, ST_IDLE, ST_ROW, ST_COL, ST_PRE,
        ST_CBR_CAS, ST_CBR_RAS, ST_CBR_PRE,
        ST_SR_CAS, ST_SR_HOLD, ST_SR_PRE
    } drc_state_t;
endpackage
`default_nettype wire

// ---- logic/drc_ctrl.sv ----
// host-side sequencer for an asynchronous page-mode dram
//
// Notes on behaviour
// - wait the power-up pause, then run at least eight refresh cycles
// - those initialization cycles are column-before-row so the counter is used
// - on reads keep write strobe high until both strobes have risen
// - output enable off before driving write data in late writes
// - never hold row low between the lower and upper self-refresh bounds
// - after self-refresh use the longer self-refresh precharge time
// - with row-only or burst refresh, run distributed refresh around self-refresh
// - with distributed refresh, issue one just before entry and after exit
// - refresh every row after self-refresh exit before entering again
`timescale 1ns/1ps
`default_nettype none
module drc_ctrl
    import drc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_wr,
    input wire logic [ADDR_W-1:0] i_row,
    input wire logic [COL_W-1:0] i_col,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_sr_req,
    input wire logic [DATA_W-1:0] i_dq,
    output logic o_ready,
    output logic o_rvalid,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_init_done,
    output logic o_sr_active,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_we_n,
    output logic o_oe_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_dq,
    output logic o_dq_oe
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    drc_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [7:0] ref_cnt_q, ref_cnt_d;
    logic ref_pend_q, ref_pend_d;
    logic [3:0] init_left_q, init_left_d;
    logic [ROWS_W-1:0] rows_q, rows_d;
    logic sr_next_q, sr_next_d;
    logic wr_q, wr_d;
    logic [COL_W-1:0] col_q, col_d;
    logic init_done_q, init_done_d;
    logic ras_q, ras_d, cas_q, cas_d, we_q, we_d, oe_q, oe_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] dq_q, dq_d, rdata_q, rdata_d;
    logic dq_oe_q, dq_oe_d, rvalid_q, rvalid_d;
    logic ref_tick, ref_take, sr_allowed;

    // accesses only start from idle with no refresh owed and no sleep entry allowed
    assign sr_allowed = i_sr_req && (rows_q == ROWS_FULL);
    assign o_ready = (st_q == ST_IDLE) && !ref_pend_q && !sr_allowed;
    assign ref_tick = (ref_cnt_q == REF_INT_LAST);
    assign ref_take = (st_q == ST_CBR_CAS);

    // ------------------------------------------------------------------
    // next-state and pin computation
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        init_left_d = init_left_q;
        rows_d = rows_q;
        sr_next_d = sr_next_q;
        wr_d = wr_q;
        col_d = col_q;
        init_done_d = init_done_q;
        ras_d = ras_q;
        cas_d = cas_q;
        we_d = we_q;
        oe_d = oe_q;
        addr_d = addr_q;
        dq_d = dq_q;
        dq_oe_d = dq_oe_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        // the interval timer is held at zero while the device refreshes itself
        if (ref_tick || st_q == ST_SR_HOLD) begin
            ref_cnt_d = 8'h00;
        end else begin
            ref_cnt_d = ref_cnt_q + 8'h01;
        end
        // a tick in the cycle the owed refresh is taken is kept
        ref_pend_d = (ref_pend_q && !ref_take) || ref_tick;
        unique case (st_q)
            ST_PWR_WAIT: begin
                cnt_d = cnt_q + 12'h001;
                if (cnt_q == PWR_PAUSE_LAST) begin
                    cnt_d = 12'h000;
                    st_d = ST_CBR_CAS;
                end
            end
            ST_IDLE: begin
                if (ref_pend_q) begin
                    st_d = ST_CBR_CAS;
                end else if (sr_allowed) begin
                    // one refresh right before entry, then straight in
                    sr_next_d = 1'b1;
                    st_d = ST_CBR_CAS;
                end else if (i_req) begin
                    st_d = ST_ROW;
                    ras_d = 1'b0;
                    addr_d = i_row;
                    col_d = i_col;
                    wr_d = i_wr;
                    // write strobe falls a full cycle ahead of column strobe
                    we_d = !i_wr;
                    oe_d = 1'b1;
                    dq_d = i_wdata;
                    dq_oe_d = i_wr;
                end
            end
            ST_ROW: begin
                st_d = ST_COL;
                cas_d = 1'b0;
                addr_d = {1'b0, col_q};
                oe_d = wr_q;
            end
            ST_COL: begin
                // both strobes and write strobe high together: read held
                st_d = ST_PRE;
                ras_d = 1'b1;
                cas_d = 1'b1;
                we_d = 1'b1;
                oe_d = 1'b1;
                dq_oe_d = 1'b0;
                if (!wr_q) begin
                    rdata_d = i_dq;
                    rvalid_d = 1'b1;
                end
            end
            ST_PRE: begin
                st_d = ST_IDLE;
            end
            ST_CBR_CAS: begin
                st_d = ST_CBR_RAS;
                ras_d = 1'b0;
            end
            ST_CBR_RAS: begin
                st_d = ST_CBR_PRE;
                ras_d = 1'b1;
                cas_d = 1'b1;
                if (rows_q != ROWS_FULL) begin
                    rows_d = rows_q + 12'h001;
                end
                if (init_left_q != 4'h0) begin
                    init_left_d = init_left_q - 4'h1;
                end
            end
            ST_CBR_PRE: begin
                if (init_left_q != 4'h0) begin
                    st_d = ST_CBR_CAS;
                    cas_d = 1'b0;
                end else if (sr_next_q) begin
                    sr_next_d = 1'b0;
                    st_d = ST_SR_CAS;
                    cas_d = 1'b0;
                end else begin
                    init_done_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            ST_SR_CAS: begin
                st_d = ST_SR_HOLD;
                ras_d = 1'b0;
                cnt_d = 12'h000;
            end
            ST_SR_HOLD: begin
                // the hold never ends short of the upper bound, so the
                // transition span between the bounds is never left early
                if (cnt_q != SR_LOW_LAST) begin
                    cnt_d = cnt_q + 12'h001;
                end else if (!i_sr_req) begin
                    st_d = ST_SR_PRE;
                    ras_d = 1'b1;
                    cas_d = 1'b1;
                    cnt_d = 12'h000;
                    rows_d = 12'h000;
                end
            end
            ST_SR_PRE: begin
                cnt_d = cnt_q + 12'h001;
                if (cnt_q == SR_PRE_LAST) begin
                    cnt_d = 12'h000;
                    st_d = ST_CBR_CAS;
                    cas_d = 1'b0;
                end
            end
        endcase
        // refresh entry from idle drops column strobe first
        if (st_q == ST_IDLE && st_d == ST_CBR_CAS) begin
            cas_d = 1'b0;
        end
        if (st_q == ST_PWR_WAIT && st_d == ST_CBR_CAS) begin
            cas_d = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_q <= ST_PWR_WAIT;
            cnt_q <= 12'h000;
            ref_cnt_q <= 8'h00;
            ref_pend_q <= 1'b0;
            init_left_q <= INIT_LOAD;
            rows_q <= ROWS_FULL;
            sr_next_q <= 1'b0;
            wr_q <= 1'b0;
            col_q <= '0;
            init_done_q <= 1'b0;
            ras_q <= 1'b1;
            cas_q <= 1'b1;
            we_q <= 1'b1;
            oe_q <= 1'b1;
            addr_q <= '0;
            dq_q <= '0;
            dq_oe_q <= 1'b0;
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ref_cnt_q <= ref_cnt_d;
            ref_pend_q <= ref_pend_d;
            init_left_q <= init_left_d;
            rows_q <= rows_d;
            sr_next_q <= sr_next_d;
            wr_q <= wr_d;
            col_q <= col_d;
            init_done_q <= init_done_d;
            ras_q <= ras_d;
            cas_q <= cas_d;
            we_q <= we_d;
            oe_q <= oe_d;
            addr_q <= addr_d;
            dq_q <= dq_d;
            dq_oe_q <= dq_oe_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_ras_n = ras_q;
    assign o_cas_n = cas_q;
    assign o_we_n = we_q;
    assign o_oe_n = oe_q;
    assign o_addr = addr_q;
    assign o_dq = dq_q;
    assign o_dq_oe = dq_oe_q;
    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;
    assign o_init_done = init_done_q;
    assign o_sr_active = (st_q == ST_SR_HOLD);
endmodule // drc_ctrl
`default_nettype wire

// ---- verification/drc_checker.sv ----
// port assertions for the dram host controller
`timescale 1ns/1ps
`default_nettype none
module drc_checker
    import drc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_wr,
    input wire logic i_sr_req,
    input wire logic o_ready,
    input wire logic o_rvalid,
    input wire logic o_init_done,
    input wire logic o_sr_active,
    input wire logic o_ras_n,
    input wire logic o_cas_n,
    input wire logic o_we_n,
    input wire logic o_oe_n,
    input wire logic o_dq_oe
);
    logic [10:0] cyc_q;
    logic [10:0] low_q;
    logic [3:0] cbr_q;
    // run lengths saturate so a long sleep never wraps into a false pass
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cyc_q <= 11'h000;
            low_q <= 11'h000;
            cbr_q <= 4'h0;
        end else begin
            cyc_q <= cyc_q + {10'h000, cyc_q != 11'h7FF};
            low_q <= o_ras_n ? 11'h000 : low_q + {10'h000, low_q != 11'h7FF};
            if ($fell(o_ras_n) && !o_cas_n && cbr_q != 4'hF)
                cbr_q <= cbr_q + 4'h1;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_cbr_start; $fell(o_cas_n) && o_ras_n; endsequence
    sequence s_sr_exit; $rose(o_ras_n) && low_q >= 11'h3E8; endsequence
    property p_pause; cyc_q < 11'h7D0 |-> o_ras_n && o_cas_n; endproperty
    a_pause: assert property (p_pause) else $error("strobe in pause");
    property p_init; $rose(o_init_done) |-> cbr_q >= 4'h8; endproperty
    a_init: assert property (p_init) else $error("few init cycles");
    property p_cbr; s_cbr_start |=> !o_ras_n && !o_cas_n; endproperty
    a_cbr: assert property (p_cbr) else $error("row not after col");
    property p_early_wr; $fell(o_we_n) |-> o_cas_n; endproperty
    a_early_wr: assert property (p_early_wr) else $error("late write");
    property p_oe_off; o_dq_oe |-> o_oe_n; endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin fight");
    property p_read_hold; !o_oe_n |-> o_we_n ##1 o_we_n; endproperty
    a_read_hold: assert property (p_read_hold) else $error("rd hold");
    property p_sr_band;
        $rose(o_ras_n) |-> low_q < 11'h064 || low_q >= 11'h3E8;
    endproperty
    a_sr_band: assert property (p_sr_band) else $error("row low band");
    property p_sr_pre; s_sr_exit |-> o_ras_n [*3]; endproperty
    a_sr_pre: assert property (p_sr_pre) else $error("short precharge");
    property p_sr_cbr; s_sr_exit |-> ##[1:156] s_cbr_start; endproperty
    a_sr_cbr: assert property (p_sr_cbr) else $error("no exit refresh");
    property p_sr_pins; o_sr_active |-> !o_ras_n && !o_cas_n; endproperty
    a_sr_pins: assert property (p_sr_pins) else $error("sleep pins");
    property p_rd_lat;
        o_ready && i_req && !i_wr && !i_sr_req |-> ##3 o_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
endmodule // drc_checker
bind drc_ctrl drc_checker i_chk (.i_ref_clk, .i_rst, .i_req, .i_wr, .i_sr_req,
    .o_ready, .o_rvalid, .o_init_done, .o_sr_active, .o_ras_n, .o_cas_n,
    .o_we_n, .o_oe_n, .o_dq_oe);
`default_nettype wire

// ---- verification/drc_dram_model.sv ----
// behavioural model of the dram on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module drc_dram_model
    import drc_pkg::*;
#(
    parameter int ACC_NS = 30
)
(
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_dq,
    output logic [DATA_W-1:0] o_dq,
    output logic [ADDR_W-1:0] o_ref_row
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] last = 8'h3C;
    int row = 0;
    int col = 0;
    initial o_ref_row = 11'h000;
    // row fall: column already low means refresh of the counter row
    always @(negedge i_ras_n) begin
        #1;
        if (!i_cas_n) o_ref_row = o_ref_row + 11'h001;
        else row = int'(i_addr);
    end
    // column fall: early write takes data here, 1 ns stands for hold time
    always @(negedge i_cas_n) begin
        #1;
        col = int'(i_addr[COL_W-1:0]);
        if (!i_ras_n && !i_we_n) mem[row * 1024 + col] = i_dq;
    end
    // write strobe falling inside an open column: late write takes data here
    always @(negedge i_we_n) begin
        #1;
        if (!i_ras_n && !i_cas_n) mem[row * 1024 + col] = i_dq;
    end
    // released pins show the inverse of the last value, never stale data
    always @(i_ras_n, i_cas_n, i_oe_n, i_we_n, col) begin
        if (!i_ras_n && !i_cas_n && !i_oe_n && i_we_n) begin
            last = mem.exists(row * 1024 + col) ? mem[row * 1024 + col] : 8'hA5;
            o_dq <= #(ACC_NS) last;
        end else begin
            o_dq = ~last;
        end
    end
endmodule // drc_dram_model
`default_nettype wire

// ---- verification/tb_dram_refresh_cycle_rules.sv ----
// self-checking bench for the dram host controller
`timescale 1ns/1ps
`default_nettype none
module tb_dram_refresh_cycle_rules import drc_pkg::*;;
    logic i_ref_clk, i_rst, i_req, i_wr, i_sr_req;
    logic ready, rvalid, init_done, sr_act, ras_n, cas_n, we_n, oe_n, dq_oe;
    logic [ADDR_W-1:0] i_row, addr, ref_row, base;
    logic [COL_W-1:0] i_col;
    logic [DATA_W-1:0] i_wdata, dut_dq, mem_dq, bus, rdata;
    logic [DATA_W-1:0] exp_mem [int];
    logic [31:0] seed = 32'h96500CF9;
    logic [31:0] q [8];
    int error_cnt = 0, num_checks = 0, cyc = 0, t = 0;
    assign bus = dq_oe ? dut_dq : mem_dq;
    drc_ctrl i_dut (.i_ref_clk, .i_rst, .i_req, .i_wr, .i_row, .i_col,
        .i_wdata, .i_sr_req, .i_dq(bus), .o_ready(ready), .o_rvalid(rvalid),
        .o_rdata(rdata), .o_init_done(init_done), .o_sr_active(sr_act),
        .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_oe_n(oe_n),
        .o_addr(addr), .o_dq(dut_dq), .o_dq_oe(dq_oe));
    drc_dram_model #(.ACC_NS(30)) i_mem (.i_ras_n(ras_n), .i_cas_n(cas_n),
        .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(addr), .i_dq(bus),
        .o_dq(mem_dq), .o_ref_row(ref_row));
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end
    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge i_ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 10000) begin
            error_cnt = error_cnt + 1;
            stop_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("FAIL %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // inputs always move 5 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #5;
    endtask
    task automatic wait_ready();
        t = 0;
        // long enough to cover the power-up pause and the init refreshes
        while (ready !== 1'b1 && t < 3000) begin
            step(1);
            t = t + 1;
        end
    endtask
    task automatic access(input logic wr, input logic [31:0] a);
        wait_ready();
        i_req = 1'b1;
        i_wr = wr;
        i_row = a[10:0];
        i_col = a[20:11];
        i_wdata = a[31:24];
        step(1);
        i_req = 1'b0;
        if (wr) begin
            exp_mem[int'(a[20:0])] = a[31:24];
        end else begin
            // read answer stands one cycle, two edges after the take
            step(2);
            check(16'(rvalid), 16'h0001);
            check(16'(rdata), 16'(exp_mem[int'(a[20:0])]));
        end
    endtask
    initial begin
        i_rst = 1'b1;
        {i_req, i_wr, i_sr_req, i_row, i_col, i_wdata} = '0;
        step(3);
        check({ras_n, cas_n, dq_oe, ready, init_done}, 16'h0018);
        i_rst = 1'b0;
        wait_ready();
        check(16'(t >= 2000), 16'h0001);
        check(16'(ref_row), 16'h0008);
        $display("test init done");
        access(1'b1, 32'hFFFFFFFF);
        access(1'b0, 32'hFFFFFFFF);
        access(1'b1, 32'h00000000);
        access(1'b0, 32'h00000000);
        for (int i = 0; i < 8; i++) q[i] = rnd();
        for (int i = 0; i < 8; i++) access(1'b1, q[i]);
        for (int i = 7; i >= 0; i--) access(1'b0, q[i]);
        $display("test access done");
        base = ref_row;
        while (ref_row === base && cyc < 9000) step(1);
        base = ref_row;
        i_sr_req = 1'b1;
        t = 0;
        while (sr_act !== 1'b1 && t < 100) begin
            step(1);
            t = t + 1;
        end
        check(16'(ref_row - base), 16'h0002);
        step(1200);
        check(16'(sr_act), 16'h0001);
        i_sr_req = 1'b0;
        base = ref_row;
        step(12);
        check({sr_act, 4'h0, ref_row - base}, 16'h0001);
        i_sr_req = 1'b1;
        step(300);
        check(16'(sr_act), 16'h0000);
        access(1'b0, q[3]);
        i_sr_req = 1'b0;
        $display("test sleep done");
        base = ref_row;
        step(400);
        check(16'(ref_row - base >= 2 && ref_row - base <= 3), 16'h0001);
        $display("test refresh done");
        i_rst = 1'b1;
        step(3);
        check({ras_n, cas_n, dq_oe, ready, init_done}, 16'h0018);
        i_rst = 1'b0;
        step(5);
        check({ras_n, cas_n, init_done}, 16'h0006);
        $display("test reset done");
        stop_test();
    end
endmodule // tb_dram_refresh_cycle_rules
`default_nettype wire
